// file: hw/cbu_map.svh
// register offsets, field positions, reset values and timing counts of the branch unit
// assumes byte addressing on a 32-bit ahb-lite bus, one register per aligned word
`ifndef CBU_MAP_SVH
`define CBU_MAP_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define CBU_DEC_W           8
`define CBU_OFS_CTRL        8'h00
`define CBU_OFS_FLAGS       8'h04
`define CBU_OFS_PC          8'h08
`define CBU_OFS_STATUS      8'h0C
`define CBU_OFS_TARGET      8'h10
`define CBU_OFS_TAKEN_CNT   8'h14
`define CBU_OFS_SKIP_CNT    8'h18

// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define CBU_CTRL_KIND_LSB   0
`define CBU_CTRL_KIND_MSB   2
`define CBU_CTRL_OFS_LSB    8
`define CBU_CTRL_OFS_MSB    15
`define CBU_CTRL_START      31

// ------------------------------------------------------------
// flag register fields
// ------------------------------------------------------------
`define CBU_FLAG_N          2
`define CBU_FLAG_V          3
`define CBU_FLAG_H          5
`define CBU_FLAG_T          6

// ------------------------------------------------------------
// status register fields
// ------------------------------------------------------------
`define CBU_STAT_BUSY       0
`define CBU_STAT_DONE       1
`define CBU_STAT_TAKEN      2
`define CBU_STAT_REJECT     3
`define CBU_STAT_CYC_LSB    4
`define CBU_STAT_CYC_MSB    5

// ------------------------------------------------------------
// reset values and timing counts
// ------------------------------------------------------------
`define CBU_RST_PC          16'h0000
`define CBU_RST_FLAGS       4'h0
`define CBU_RST_CNT         16'h0000
`define CBU_CYC_SKIP        2'h1
`define CBU_CYC_TAKEN       2'h2

`endif

// file: hw/cbu_pkg.sv
// types shared by the branch unit and its helper modules
// assumes cbu_map.svh supplies all numeric constants
package cbu_pkg;

    // branch kinds in register encoding order 0..7
    typedef enum logic [2:0] {
        branch_signed_less,
        branch_signed_greater_equal,
        branch_halfcarry_set,
        branch_halfcarry_clear,
        branch_transfer_set,
        branch_transfer_clear,
        branch_overflow_set,
        branch_nonnegative
    } cbu_kind_t;

    typedef struct packed {
        logic t;
        logic h;
        logic v;
        logic n;
    } cbu_flags_t;

    typedef struct packed {
        cbu_kind_t  kind;
        logic [7:0] offset;
    } cbu_cmd_t;

    typedef enum logic [1:0] {
        cbu_idle,
        cbu_eval,
        cbu_load
    } cbu_state_t;

endpackage

// file: hw/cbu_cond_eval.sv
// condition test of one conditional relative branch against the status flags
// assumes flags are stable while the kind is evaluated; purely combinational
module cbu_cond_eval
    import cbu_pkg::*;
(
    // command and flags
    input  wire cbu_kind_t  i_kind,
    input  wire cbu_flags_t i_flags,
    // result
    output logic            o_taken
);

    wire sign_lt = i_flags.n ^ i_flags.v;

    always_comb begin
        case (i_kind)
            branch_signed_less:          o_taken = (sign_lt == 1'b1);
            branch_signed_greater_equal: o_taken = (sign_lt == 1'b0);
            branch_halfcarry_set:        o_taken = (i_flags.h == 1'b1);
            branch_halfcarry_clear:      o_taken = (i_flags.h == 1'b0);
            branch_transfer_set:         o_taken = (i_flags.t == 1'b1);
            branch_transfer_clear:       o_taken = (i_flags.t == 1'b0);
            branch_overflow_set:         o_taken = (i_flags.v == 1'b1);
            branch_nonnegative:          o_taken = (i_flags.n == 1'b0);
            default:                     o_taken = 1'b0;
        endcase
    end

endmodule

// file: hw/cbu_target_adder.sv
// program counter arithmetic: sequential successor and relative branch target
// assumes the offset field holds a two's complement value in its low OFFSET_W bits
module cbu_target_adder #(
    parameter int PC_W     = 16,
    parameter int OFFSET_W = 7
) (
    // operands
    input  wire logic [PC_W-1:0] i_pc,
    input  wire logic [7:0]      i_offset,
    // results
    output logic [PC_W-1:0]      o_next_seq,
    output logic [PC_W-1:0]      o_target
);

    if (OFFSET_W < 2 || OFFSET_W > 8 || OFFSET_W >= PC_W) begin : g_chk_w
        $error("OFFSET_W must lie between 2 and 8 and be below PC_W");
    end

    localparam logic [PC_W-1:0] ONE = PC_W'(1);

    // sign extension lets targets lie before or after the branch
    wire [PC_W-1:0] ofs_sext = {{(PC_W-OFFSET_W){i_offset[OFFSET_W-1]}},
                                i_offset[OFFSET_W-1:0]};

    assign o_next_seq = i_pc + ONE;
    assign o_target   = i_pc + ofs_sext + ONE;

endmodule

// file: hw/cbu_branch_unit.sv
// conditional relative branch unit with an ahb-lite register slave
// assumes one ahb-lite master, hready fed back from o_hreadyout, word transfers only
//
// The AHB-Lite register port and the address map are this design's own decisions.
`include "cbu_map.svh"

// What this block does
// - signed-less branch taken when negative xor overflow is one
// - signed greater-or-equal branch taken only when negative xor overflow is zero
// - half-carry-set branch taken only when half carry is one
// - half-carry-clear branch taken only when half carry is zero
// - transfer-set branch redirects pc only when transfer bit is one
// - transfer-clear branch redirects pc only when transfer bit is zero
// - overflow-set branch taken only when overflow is one
// - nonnegative branch taken only when negative flag is zero
// - taken branch loads pc with pc plus offset plus one
// - flags are never modified by a branch; each branch finishes in one or two cycles
module cbu_branch_unit
    import cbu_pkg::*;
#(
    parameter int PC_W     = 16,
    parameter int OFFSET_W = 7
) (
    // clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_sys_rst,
    // ahb-lite slave
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic [31:0]      o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    // core side
    output logic [PC_W-1:0]  o_pc,
    output logic             o_pc_load,
    output logic             o_taken,
    output logic             o_busy
);

    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    if (PC_W < 8 || PC_W > 32) begin : g_chk_pc
        $error("PC_W must lie between 8 and 32");
    end
    if (OFFSET_W < 2 || OFFSET_W > 8 || OFFSET_W >= PC_W) begin : g_chk_ofs
        $error("OFFSET_W must lie between 2 and 8 and be below PC_W");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    cbu_state_t      state;
    cbu_cmd_t        cmd;
    cbu_flags_t      flags;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] target;
    logic            done;
    logic            taken_last;
    logic            reject;
    logic [1:0]      cycles;
    logic [15:0]     taken_cnt;
    logic [15:0]     skip_cnt;
    logic            wr_pend;
    logic [7:0]      wr_addr;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    wire        addr_hit  = (i_haddr[31:`CBU_DEC_W] == '0);
    wire        xfer      = i_hsel & i_htrans[1] & i_hready;
    wire        rd_req    = xfer & ~i_hwrite;
    wire        wr_req    = xfer & i_hwrite & addr_hit;
    wire [7:0]  rd_ofs    = i_haddr[`CBU_DEC_W-1:0];

    // ------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------
    wire        wr_ctrl   = wr_pend & (wr_addr == `CBU_OFS_CTRL);
    wire        wr_flags  = wr_pend & (wr_addr == `CBU_OFS_FLAGS);
    wire        wr_pc     = wr_pend & (wr_addr == `CBU_OFS_PC);
    wire        wr_status = wr_pend & (wr_addr == `CBU_OFS_STATUS);
    wire        wr_tcnt   = wr_pend & (wr_addr == `CBU_OFS_TAKEN_CNT);
    wire        wr_scnt   = wr_pend & (wr_addr == `CBU_OFS_SKIP_CNT);

    wire        idle      = (state == cbu_idle);
    wire        start_req = wr_ctrl & i_hwdata[`CBU_CTRL_START];
    wire        start     = start_req & idle;
    wire        start_bad = start_req & ~idle;

    // ------------------------------------------------------------
    // condition and target
    // ------------------------------------------------------------
    wire             cond_taken;
    wire [PC_W-1:0]  pc_seq;
    wire [PC_W-1:0]  pc_target;

    cbu_cond_eval u_cond (
        .i_kind  (cmd.kind),
        .i_flags (flags),
        .o_taken (cond_taken)
    );

    cbu_target_adder #(
        .PC_W     (PC_W),
        .OFFSET_W (OFFSET_W)
    ) u_adder (
        .i_pc       (pc),
        .i_offset   (cmd.offset),
        .o_next_seq (pc_seq),
        .o_target   (pc_target)
    );

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    wire eval_skip  = (state == cbu_eval) & ~cond_taken;
    wire eval_take  = (state == cbu_eval) & cond_taken;
    wire load_done  = (state == cbu_load);
    wire finish     = eval_skip | load_done;

    cbu_state_t next_state;
    always_comb begin
        case (state)
            cbu_idle: next_state = start ? cbu_eval : cbu_idle;
            cbu_eval: next_state = cond_taken ? cbu_load : cbu_idle;
            cbu_load: next_state = cbu_idle;
            default:  next_state = cbu_idle;
        endcase
    end

    wire [PC_W-1:0] sw_pc    = i_hwdata[PC_W-1:0];
    wire [PC_W-1:0] next_pc  = eval_skip ? pc_seq :
                               load_done ? target :
                               (wr_pc & idle) ? sw_pc : pc;

    wire cbu_flags_t sw_flags = '{t: i_hwdata[`CBU_FLAG_T], h: i_hwdata[`CBU_FLAG_H],
                                  v: i_hwdata[`CBU_FLAG_V], n: i_hwdata[`CBU_FLAG_N]};

    // ------------------------------------------------------------
    // status bits and counters
    // ------------------------------------------------------------
    // sticky bits: a hardware set wins over a software clear in the same cycle
    wire next_done   = finish | (done & ~(wr_status & i_hwdata[`CBU_STAT_DONE]));
    wire next_reject = start_bad | (reject & ~(wr_status & i_hwdata[`CBU_STAT_REJECT]));

    wire [15:0] next_tcnt = load_done ? taken_cnt + 16'h0001 :
                            wr_tcnt ? `CBU_RST_CNT : taken_cnt;
    wire [15:0] next_scnt = eval_skip ? skip_cnt + 16'h0001 :
                            wr_scnt ? `CBU_RST_CNT : skip_cnt;

    wire cbu_cmd_t sw_cmd = '{kind:   cbu_kind_t'(i_hwdata[`CBU_CTRL_KIND_MSB:`CBU_CTRL_KIND_LSB]),
                              offset: i_hwdata[`CBU_CTRL_OFS_MSB:`CBU_CTRL_OFS_LSB]};

    // ------------------------------------------------------------
    // state, command and program counter
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            state <= cbu_idle;
        end else begin
            state <= next_state;
        end
    end

    // command fields are latched only when a start is accepted
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            cmd <= '0;
        end else if (start) begin
            cmd <= sw_cmd;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            pc <= PC_W'(`CBU_RST_PC);
        end else begin
            pc <= next_pc;
        end
    end

    // flags change only by software; the branch path never writes them
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            flags <= cbu_flags_t'(`CBU_RST_FLAGS);
        end else if (wr_flags) begin
            flags <= sw_flags;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            target     <= '0;
            taken_last <= 1'b0;
            cycles     <= 2'h0;
        end else if (eval_take) begin
            target     <= pc_target;
            taken_last <= 1'b1;
            cycles     <= `CBU_CYC_TAKEN;
        end else if (eval_skip) begin
            taken_last <= 1'b0;
            cycles     <= `CBU_CYC_SKIP;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            done   <= 1'b0;
            reject <= 1'b0;
        end else begin
            done   <= next_done;
            reject <= next_reject;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            taken_cnt <= `CBU_RST_CNT;
            skip_cnt  <= `CBU_RST_CNT;
        end else begin
            taken_cnt <= next_tcnt;
            skip_cnt  <= next_scnt;
        end
    end

    // ------------------------------------------------------------
    // core side outputs
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_pc <= PC_W'(`CBU_RST_PC);
        end else begin
            o_pc <= next_pc;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_pc_load <= 1'b0;
            o_taken   <= 1'b0;
            o_busy    <= 1'b0;
        end else begin
            o_pc_load <= finish;
            o_taken   <= load_done;
            o_busy    <= (next_state != cbu_idle);
        end
    end

    // ------------------------------------------------------------
    // register read
    // ------------------------------------------------------------
    wire [31:0] rd_ctrl   = {16'h0000, cmd.offset, 5'h00, cmd.kind};
    wire [31:0] rd_flags  = {25'h0, flags.t, flags.h, 1'b0, flags.v, flags.n, 2'h0};
    wire [31:0] rd_pc     = {{(32-PC_W){1'b0}}, pc};
    wire [31:0] rd_status = {26'h0, cycles, reject, taken_last, done, ~idle};
    wire [31:0] rd_target = {{(32-PC_W){1'b0}}, target};
    wire [31:0] rd_tcnt   = {16'h0000, taken_cnt};
    wire [31:0] rd_scnt   = {16'h0000, skip_cnt};

    wire        sel_ctrl   = (rd_ofs == `CBU_OFS_CTRL);
    wire        sel_flags  = (rd_ofs == `CBU_OFS_FLAGS);
    wire        sel_pc     = (rd_ofs == `CBU_OFS_PC);
    wire        sel_status = (rd_ofs == `CBU_OFS_STATUS);
    wire        sel_target = (rd_ofs == `CBU_OFS_TARGET);
    wire        sel_tcnt   = (rd_ofs == `CBU_OFS_TAKEN_CNT);
    wire        sel_scnt   = (rd_ofs == `CBU_OFS_SKIP_CNT);

    wire [31:0] rd_word = ~addr_hit  ? 32'h0000_0000 :
                          sel_ctrl   ? rd_ctrl   :
                          sel_flags  ? rd_flags  :
                          sel_pc     ? rd_pc     :
                          sel_status ? rd_status :
                          sel_target ? rd_target :
                          sel_tcnt   ? rd_tcnt   :
                          sel_scnt   ? rd_scnt   : 32'h0000_0000;

    // ------------------------------------------------------------
    // bus phases
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            wr_pend     <= 1'b0;
            wr_addr     <= 8'h00;
            o_hrdata    <= 32'h0000_0000;
            o_hreadyout <= 1'b1;
            o_hresp     <= 1'b0;
        end else begin
            wr_pend     <= wr_req;
            wr_addr     <= wr_req ? rd_ofs : wr_addr;
            o_hrdata    <= rd_req ? rd_word : 32'h0000_0000;
            o_hreadyout <= 1'b1;
            o_hresp     <= 1'b0;
        end
    end

endmodule

// file: tb/cbu_branch_unit_chk.sv
// checker: bus answer and branch timing relations at the branch unit ports
// assumes a bind to cbu_branch_unit, one clock, synchronous active-high reset
module cbu_branch_unit_chk
    import cbu_pkg::*;
#(
    parameter int PC_W     = 16,
    parameter int OFFSET_W = 7
) (
    // clock and reset
    input wire logic            i_mclk,
    input wire logic            i_sys_rst,
    // bus side
    input wire logic            i_hsel,
    input wire logic [1:0]      i_htrans,
    input wire logic            i_hwrite,
    input wire logic            i_hready,
    input wire logic [31:0]     o_hrdata,
    input wire logic            o_hreadyout,
    input wire logic            o_hresp,
    // core side
    input wire logic [PC_W-1:0] o_pc,
    input wire logic            o_pc_load,
    input wire logic            o_taken,
    input wire logic            o_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    wire rd_req = i_hsel & i_htrans[1] & i_hready & ~i_hwrite;

    a_resp_okay: assert property (o_hresp == 1'b0) else $error("response not okay");
    a_ready_high: assert property (o_hreadyout == 1'b1) else $error("wait state seen");
    a_rdata_idle: assert property (!$past(rd_req) |-> o_hrdata == 32'h0)
        else $error("read data outside data phase");
    a_taken_loads: assert property (o_taken |-> o_pc_load)
        else $error("taken without pc load");
    a_load_pulse: assert property (o_pc_load |=> !o_pc_load)
        else $error("pc load longer than one cycle");
    a_busy_bound: assert property ($rose(o_busy) |-> ##[1:2] !o_busy)
        else $error("branch longer than two cycles");
    a_skip_one: assert property (o_pc_load && !o_taken |-> $past(o_busy) && !$past(o_busy, 2))
        else $error("untaken branch not one cycle");
    a_taken_two: assert property (o_taken |-> $past(o_busy) && $past(o_busy, 2) && !$past(o_busy, 3))
        else $error("taken branch not two cycles");
    a_skip_inc: assert property (o_pc_load && !o_taken |-> o_pc == PC_W'($past(o_pc) + 1))
        else $error("untaken branch pc not plus one");
    a_pc_hold_busy: assert property (o_busy |-> $stable(o_pc))
        else $error("pc moved while busy");

    cover property (o_taken);
    cover property (o_pc_load && !o_taken);
    cover property (rd_req);
endmodule

// file: tb/tb_top.sv
// testbench: drives the branch unit over ahb-lite and checks branch results
// assumes design files and checker compiled first, hready fed from hreadyout
`include "cbu_map.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_mclk    = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic        i_hsel    = 1'b0;
    logic [31:0] i_haddr   = 32'h0;
    logic [1:0]  i_htrans  = 2'h0;
    logic        i_hwrite  = 1'b0;
    logic [2:0]  i_hsize   = 3'h2;
    logic [31:0] i_hwdata  = 32'h0;
    wire  [31:0] o_hrdata;
    wire         o_hreadyout;
    wire         o_hresp;
    wire  [15:0] o_pc;
    wire         o_pc_load;
    wire         o_taken;
    wire         o_busy;
    int          fail_count   = 0;
    int          total_checks = 0;
    int          ntk          = 0;
    int          nsk          = 0;

    always #2 i_mclk = ~i_mclk;

    cbu_branch_unit cbu_branch_unit_inst (
        .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_hsel(i_hsel), .i_haddr(i_haddr),
        .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
        .i_hready(o_hreadyout), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout),
        .o_hresp(o_hresp), .o_pc(o_pc), .o_pc_load(o_pc_load), .o_taken(o_taken),
        .o_busy(o_busy)
    );

    // ------------------------------------------------------------
    // bus tasks
    // ------------------------------------------------------------
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rdv);
        @(posedge i_mclk);
        i_hsel   <= 1'b1;
        i_haddr  <= a;
        i_htrans <= 2'h2;
        i_hwrite <= w;
        @(posedge i_mclk);
        while (o_hreadyout !== 1'b1) @(posedge i_mclk);
        i_htrans <= 2'h0;
        i_hsel   <= 1'b0;
        i_hwdata <= w ? wd : 32'h0;
        @(posedge i_mclk);
        while (o_hreadyout !== 1'b1) @(posedge i_mclk);
        rdv = o_hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        bus(1'b0, a, 32'h0, d);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask

    task automatic stop_test();
        if (fail_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // one branch: f is {t, h, v, n}
    // ------------------------------------------------------------
    task automatic run_branch(input int k, input logic [3:0] f, input logic [6:0] off,
                              input logic [15:0] pc0);
        logic [31:0] fw;
        logic [31:0] d;
        logic        tk;
        logic [15:0] exp_pc;
        int          n;
        fw = {25'h0, f[3], f[2], 1'b0, f[1], f[0], 2'h0};
        case (k)
            0: tk = f[0] ^ f[1];
            1: tk = ~(f[0] ^ f[1]);
            2: tk = f[2];
            3: tk = ~f[2];
            4: tk = f[3];
            5: tk = ~f[3];
            6: tk = f[1];
            default: tk = ~f[0];
        endcase
        exp_pc = tk ? pc0 + {{9{off[6]}}, off} + 16'h1 : pc0 + 16'h1;
        wr(`CBU_OFS_FLAGS, fw);
        wr(`CBU_OFS_PC, {16'h0, pc0});
        wr(`CBU_OFS_CTRL, {1'b1, 15'h0, 1'b0, off, 5'h0, 3'(k)});
        d = 32'h1;
        n = 0;
        while (d[0] !== 1'b0 && n < 8) begin
            rd(`CBU_OFS_STATUS, d);
            n++;
        end
        chk(d, {26'h0, tk ? 2'h2 : 2'h1, 1'b0, tk, 2'h2});
        rd(`CBU_OFS_PC, d);
        chk(d, {16'h0, exp_pc});
        chk({15'h0, o_busy, o_pc}, {16'h0, exp_pc});
        rd(`CBU_OFS_FLAGS, d);
        chk(d, fw);
        if (tk) begin
            ntk++;
            rd(`CBU_OFS_TARGET, d);
            chk(d, {16'h0, exp_pc});
        end else begin
            nsk++;
        end
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        logic [31:0] d;
        repeat (10) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        rd(`CBU_OFS_PC, d);
        chk(d, 32'h0);
        rd(`CBU_OFS_STATUS, d);
        chk(d, 32'h0);
        for (int k = 0; k < 8; k++) begin
            for (int f = 0; f < 16; f++) begin
                run_branch(k, 4'(f), 7'((k * 16 + f) * 13), 16'((k * 4099 + f * 37) ^ 16'hFFF8));
            end
        end
        rd(`CBU_OFS_TAKEN_CNT, d);
        chk(d, 32'(ntk));
        rd(`CBU_OFS_SKIP_CNT, d);
        chk(d, 32'(nsk));
        wr(`CBU_OFS_STATUS, 32'h0000000A);
        rd(`CBU_OFS_STATUS, d);
        chk(d, 32'h00000010);
        wr(`CBU_OFS_TAKEN_CNT, 32'h0);
        rd(`CBU_OFS_TAKEN_CNT, d);
        chk(d, 32'h0);
        rd(32'h0000001C, d);
        chk(d, 32'h0);
        rd(32'h00000108, d);
        chk(d, 32'h0);
        stop_test();
    end

    initial begin
        #200000;
        fail_count++;
        stop_test();
    end
endmodule

bind cbu_branch_unit cbu_branch_unit_chk #(.PC_W(PC_W), .OFFSET_W(OFFSET_W)) cbu_branch_unit_chk_inst (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_hsel(i_hsel), .i_htrans(i_htrans),
    .i_hwrite(i_hwrite), .i_hready(i_hready), .o_hrdata(o_hrdata),
    .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_pc(o_pc), .o_pc_load(o_pc_load),
    .o_taken(o_taken), .o_busy(o_busy)
);
